/* rtl/atr_pkg.sv */
// Purpose: Shared constants and carriers for the analog trigger block
// Assumes: 32-bit classic Wishbone, 8-bit trigger level codes
// Notes: Offsets are byte addresses of aligned words
package atr_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_TRIG = 8'h00;
    localparam logic [7:0] OFF_ROUTE = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_CALCMD = 8'h0C;
    localparam logic [7:0] OFF_CALREC = 8'h10;
    localparam int CALCMD_STORE = 4;
    localparam int CALCMD_LOAD = 5;
    // ------------------------------------------------------------
    // Trigger conditions and sources
    // ------------------------------------------------------------
    localparam logic [2:0] COND_BELOW = 3'h0;
    localparam logic [2:0] COND_ABOVE = 3'h1;
    localparam logic [2:0] COND_INSIDE = 3'h2;
    localparam logic [2:0] COND_HHYST = 3'h3;
    localparam logic [2:0] COND_LHYST = 3'h4;
    localparam logic SRC_PIN = 1'h0;
    localparam logic SRC_CONV = 1'h1;
    localparam logic [1:0] TSRC_INT = 2'h0;
    localparam logic [1:0] TSRC_AUX = 2'h1;
    localparam logic [1:0] TSRC_BUS = 2'h2;
    // ------------------------------------------------------------
    // Level scale of the pin source: offset binary
    // ------------------------------------------------------------
    localparam int PIN_RANGE_MV = 10000;
    localparam int PIN_STEP_MV = 78;
    localparam logic [7:0] CODE_MINUS_FULL = 8'h00;
    localparam logic [7:0] CODE_ZERO = 8'h80;
    localparam logic [7:0] CODE_TOP = 8'hFF;
    localparam int CONV_STEPS = 256;
    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int NUM_TIMING = 7;
    localparam int NUM_BANKS = 4;
    localparam logic [31:0] TRIG_RESET = 32'h0000_0000;
    localparam logic [31:0] ROUTE_RESET = 32'h0000_0000;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
        logic [2:0] cond;
        logic srcSel;
    } atr_trig_cfg_t;
    typedef struct packed {
        logic [6:0] master;
        logic [13:0] srcSel;
    } atr_route_cfg_t;
    typedef struct packed {
        logic [15:0] date;
        logic [7:0] temp;
        logic [7:0] trim;
    } atr_cal_rec_t;
endpackage : atr_pkg

/* rtl/atr_trigger_routing.sv */
// Purpose: Analog trigger detector, timing routing and calibration banks
// Assumes: Trigger levels arrive already digitised, synchronous to clk
// Notes: One detector serves both input and output conversion
//
// Chosen here: the register offsets and register access over Wishbone.
`timescale 1ns/1ns
module atr_trigger_routing #(
    parameter logic [31:0] FACTORY_CAL = 32'h0000_0080 // Arbitrary value
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sampleStrobe,
    input wire logic [7:0] pinLevel,
    input wire logic [7:0] convLevel,
    output logic analogTrigger,
    input wire logic [6:0] internalTiming,
    input wire logic [6:0] auxFunctionIn,
    input wire logic [6:0] syncBusIn,
    output logic [6:0] syncBusOut,
    output logic [6:0] syncBusOe,
    output logic [6:0] timingOut,
    output logic [7:0] trimCode
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    atr_pkg::atr_trig_cfg_t trigCfg, next_trigCfg;
    atr_pkg::atr_route_cfg_t routeCfg, next_routeCfg;
    atr_pkg::atr_cal_rec_t calStage, next_calStage;
    atr_pkg::atr_cal_rec_t calActive, next_calActive;
    logic [1:0] calBank, next_calBank;
    logic [31:0] next_wb_dat_o;
    logic next_wb_ack_o;
    logic [31:0] userBank [1:3];
    logic bankWrite;
    logic access;
    logic wrAccess;
    logic [7:0] detLevel;
    logic hystState, next_hystState;

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                                input logic [31:0] wr,
                                                input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wr[b*8 +: 8];
            end
        end
        return res;
    endfunction : mergeBytes

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrAccess = access && wb_we_i;

    // ------------------------------------------------------------
    // Wishbone slave: one wait state, unmapped reads return zero
    // ------------------------------------------------------------
    always_comb begin
        next_trigCfg = trigCfg;
        next_routeCfg = routeCfg;
        next_calStage = calStage;
        next_calActive = calActive;
        next_calBank = calBank;
        next_wb_ack_o = access;
        next_wb_dat_o = 32'h0000_0000;
        bankWrite = 1'b0;
        if (wrAccess) begin
            case (wb_adr_i)
                atr_pkg::OFF_TRIG: begin
                    next_trigCfg = atr_pkg::atr_trig_cfg_t'(
                        20'(mergeBytes(32'(trigCfg), wb_dat_i, wb_sel_i)));
                end
                atr_pkg::OFF_ROUTE: begin
                    next_routeCfg = atr_pkg::atr_route_cfg_t'(
                        21'(mergeBytes(32'(routeCfg), wb_dat_i, wb_sel_i)));
                end
                atr_pkg::OFF_CALREC: begin
                    next_calStage = mergeBytes(calStage, wb_dat_i, wb_sel_i);
                end
                atr_pkg::OFF_CALCMD: begin
                    if (wb_sel_i[0]) begin
                        next_calBank = wb_dat_i[1:0];
                        // Factory bank is read-only
                        bankWrite = wb_dat_i[atr_pkg::CALCMD_STORE]
                            && (wb_dat_i[1:0] != 2'h0);
                        if (wb_dat_i[atr_pkg::CALCMD_LOAD]) begin
                            next_calActive = (wb_dat_i[1:0] == 2'h0) ? FACTORY_CAL
                                : userBank[wb_dat_i[1:0]];
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (access) begin
            case (wb_adr_i)
                atr_pkg::OFF_TRIG: next_wb_dat_o = 32'(trigCfg);
                atr_pkg::OFF_ROUTE: next_wb_dat_o = 32'(routeCfg);
                atr_pkg::OFF_STAT: next_wb_dat_o = {15'h0000, timingOut,
                    analogTrigger, hystState, detLevel};
                atr_pkg::OFF_CALCMD: next_wb_dat_o = {30'h0000_0000, calBank};
                atr_pkg::OFF_CALREC: next_wb_dat_o = calStage;
                default: next_wb_dat_o = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            trigCfg <= atr_pkg::atr_trig_cfg_t'(atr_pkg::TRIG_RESET[19:0]);
            routeCfg <= atr_pkg::atr_route_cfg_t'(atr_pkg::ROUTE_RESET[20:0]);
            calStage <= 32'h0000_0000;
            calActive <= FACTORY_CAL;
            calBank <= 2'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            trigCfg <= next_trigCfg;
            routeCfg <= next_routeCfg;
            calStage <= next_calStage;
            calActive <= next_calActive;
            calBank <= next_calBank;
            wb_ack_o <= next_wb_ack_o;
            wb_dat_o <= next_wb_dat_o;
        end
    end

    // Storage keeps its content through reset, as nonvolatile memory would
    always_ff @(posedge clk) begin
        if (bankWrite) begin
            userBank[wb_dat_i[1:0]] <= calStage;
        end
    end

    assign trimCode = calActive.trim;

    // ------------------------------------------------------------
    // Analog trigger detector
    // ------------------------------------------------------------
    // Codes of either source compare directly; scale is set upstream
    logic next_analogTrigger;
    logic aboveHigh;
    logic belowLow;

    assign detLevel = (trigCfg.srcSel == atr_pkg::SRC_CONV) ? convLevel
        : pinLevel;
    assign aboveHigh = detLevel > trigCfg.high;
    assign belowLow = detLevel < trigCfg.low;

    always_comb begin
        next_hystState = hystState;
        next_analogTrigger = analogTrigger;
        if (sampleStrobe) begin
            case (trigCfg.cond)
                atr_pkg::COND_BELOW: next_analogTrigger = belowLow;
                atr_pkg::COND_ABOVE: next_analogTrigger = aboveHigh;
                atr_pkg::COND_INSIDE: begin
                    next_analogTrigger = (detLevel > trigCfg.low)
                        && (detLevel < trigCfg.high);
                end
                atr_pkg::COND_HHYST: begin
                    if (aboveHigh) begin
                        next_hystState = 1'b1;
                    end else if (belowLow) begin
                        next_hystState = 1'b0;
                    end
                    next_analogTrigger = next_hystState;
                end
                atr_pkg::COND_LHYST: begin
                    if (belowLow) begin
                        next_hystState = 1'b1;
                    end else if (aboveHigh) begin
                        next_hystState = 1'b0;
                    end
                    next_analogTrigger = next_hystState;
                end
                default: next_analogTrigger = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hystState <= 1'b0;
            analogTrigger <= 1'b0;
        end else begin
            hystState <= next_hystState;
            analogTrigger <= next_analogTrigger;
        end
    end

    // ------------------------------------------------------------
    // Timing signal routing
    // ------------------------------------------------------------
    logic [6:0] next_timingOut;
    logic [6:0] next_syncBusOut;
    logic [6:0] next_syncBusOe;

    for (genvar i = 0; i < atr_pkg::NUM_TIMING; i++) begin : g_route
        logic [1:0] sel;
        logic localSrc;
        assign sel = routeCfg.srcSel[i*2 +: 2];
        // A master never listens to the bus it drives itself
        assign localSrc = (sel == atr_pkg::TSRC_AUX) ? auxFunctionIn[i]
            : internalTiming[i];
        always_comb begin
            case (sel)
                atr_pkg::TSRC_BUS: begin
                    next_timingOut[i] = routeCfg.master[i] ? internalTiming[i]
                        : syncBusIn[i];
                end
                atr_pkg::TSRC_AUX: next_timingOut[i] = auxFunctionIn[i];
                default: next_timingOut[i] = internalTiming[i];
            endcase
            next_syncBusOut[i] = localSrc;
            next_syncBusOe[i] = routeCfg.master[i];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            timingOut <= 7'h00;
            syncBusOut <= 7'h00;
            syncBusOe <= 7'h00;
        end else begin
            timingOut <= next_timingOut;
            syncBusOut <= next_syncBusOut;
            syncBusOe <= next_syncBusOe;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence wbReq;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence wbAns;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    wb_ack_once_a: assert property (wbReq |=> wbAns)
        else $error("Ack not a single pulse");
    reset_no_drive_a: assert property (disable iff (1'b0)
        reset |=> (syncBusOe == 7'h00) && (routeCfg == '0))
        else $error("Bus driven after reset");
    below_low_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_BELOW
        |=> analogTrigger == $past(belowLow))
        else $error("Below-low mismatch");
    above_high_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_ABOVE
        |=> analogTrigger == $past(aboveHigh))
        else $error("Above-high mismatch");
    inside_region_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_INSIDE
        && detLevel == trigCfg.low |=> !analogTrigger)
        else $error("Inside-region edge asserted");
    high_hyst_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_HHYST
        && aboveHigh |=> analogTrigger)
        else $error("High-hysteresis missed");
    low_hyst_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_LHYST
        && belowLow |=> analogTrigger)
        else $error("Low-hysteresis missed");
    hyst_hold_a: assert property (
        sampleStrobe && trigCfg.cond == atr_pkg::COND_HHYST
        && !aboveHigh && !belowLow |=> analogTrigger == $past(hystState))
        else $error("Hysteresis band not held");
    sample_hold_a: assert property (!sampleStrobe |=> $stable(analogTrigger))
        else $error("Trigger moved off sample");
    master_drive_a: assert property (##1 syncBusOe == $past(routeCfg.master))
        else $error("Bus enable not from master bits");
    source_pick_a: assert property (
        sampleStrobe && trigCfg.srcSel == atr_pkg::SRC_PIN
        && trigCfg.cond == atr_pkg::COND_ABOVE
        |=> analogTrigger == ($past(pinLevel) > $past(trigCfg.high)))
        else $error("Wrong trigger source");
endmodule : atr_trigger_routing

/* rtl/_unused_placeholder_removed.sv */
`timescale 1ns/1ns

/* tb/atr_sync_peer.sv */
// Purpose: Another board sharing the sync bus
// Assumes: Peer drives only the lines it masters
// Notes: Undriven lines toggle, so a stale level never passes
`timescale 1ns/1ns
module atr_sync_peer (
    input wire logic clk,
    input wire logic [6:0] syncBusOut,
    input wire logic [6:0] syncBusOe,
    input wire logic [6:0] peerMaster,
    input wire logic [6:0] peerValue,
    output logic [6:0] syncBusIn
);
    logic [6:0] idle = 7'h00;
    always @(posedge clk) begin
        idle <= ~idle;
    end
    // Wire level resolved from both drivers
    assign syncBusIn = (syncBusOe & syncBusOut) | (~syncBusOe & peerMaster & peerValue)
        | (~syncBusOe & ~peerMaster & idle);
endmodule : atr_sync_peer

/* tb/analog_trigger_and_timing_routing_bench.sv */
// Purpose: Self-checking bench for trigger detector, routing and cal banks
// Assumes: Reads are judged from a queue of expected words
// Notes: Thresholds fixed at low 60h, high A0h
`timescale 1ns/1ns
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin nErrors++; \
    $display("Error at %0t: got %h exp %h", $time, g, e); end end
module analog_trigger_and_timing_routing_bench;
    localparam logic [31:0] FCAL = 32'h0000_0080; // Arbitrary value
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, strobe = 1'b0, analogTrigger, hy = 1'b0;
    logic [7:0] adr = 8'h00, pinLevel = 8'h00, convLevel = 8'h00, trimCode;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000, rdat;
    logic [6:0] intT = 7'h00, auxT = 7'h00, peerMaster = 7'h00, peerValue = 7'h00;
    logic [6:0] busIn, busOut, busOe, timingOut;
    logic [31:0] expQ[$], mskQ[$];
    int nErrors = 0, nTests = 0, seed = 32'haf82_2d06;
    atr_trigger_routing #(.FACTORY_CAL(FCAL)) i_atr_trigger_routing (
        .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .sampleStrobe(strobe), .pinLevel(pinLevel), .convLevel(convLevel),
        .analogTrigger(analogTrigger), .internalTiming(intT), .auxFunctionIn(auxT),
        .syncBusIn(busIn), .syncBusOut(busOut), .syncBusOe(busOe),
        .timingOut(timingOut), .trimCode(trimCode));
    atr_sync_peer i_atr_sync_peer (.clk(clk), .syncBusOut(busOut), .syncBusOe(busOe),
        .peerMaster(peerMaster), .peerValue(peerValue), .syncBusIn(busIn));
    initial begin
        forever #5 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Bus master and read monitor
    // ------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, s};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (n >= 20) nErrors++;
        {cyc, stb} <= 2'b00;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        expQ.push_back(e & m);
        mskQ.push_back(m);
        wb(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) begin
            if (expQ.size() == 0) nErrors++;
            else begin
                `CHK(rdat & mskQ[0], expQ[0])
                void'(expQ.pop_front());
                void'(mskQ.pop_front());
            end
        end
    end
    // ------------------------------------------------------------
    // One strobed sample, then a hold check without strobe
    // ------------------------------------------------------------
    task automatic smp(input logic [2:0] c, input logic s, input logic [7:0] v);
        logic t;
        @(posedge clk);
        {strobe, pinLevel, convLevel} <= {1'b1, s ? ~v : v, s ? v : ~v};
        @(posedge clk);
        strobe <= 1'b0;
        case (c)
            atr_pkg::COND_BELOW: t = v < 8'h60;
            atr_pkg::COND_ABOVE: t = v > 8'hA0;
            atr_pkg::COND_INSIDE: t = v > 8'h60 && v < 8'hA0;
            atr_pkg::COND_HHYST: begin
                hy = (v > 8'hA0) ? 1'b1 : (v < 8'h60) ? 1'b0 : hy;
                t = hy;
            end
            atr_pkg::COND_LHYST: begin
                hy = (v < 8'h60) ? 1'b1 : (v > 8'hA0) ? 1'b0 : hy;
                t = hy;
            end
            default: t = 1'b0;
        endcase
        rd(atr_pkg::OFF_STAT, {22'h0, t, hy, v}, 32'h0000_03FF);
        `CHK(analogTrigger, t)
        {pinLevel, convLevel} <= 16'($random(seed));
        repeat (2) @(posedge clk);
        `CHK(analogTrigger, t)
    endtask : smp
    task automatic conclude;
        if (nErrors == 0 && nTests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        #500000;
        nErrors++;
        conclude();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] rt, tc, rec[4];
        logic [6:0] te, loc;
        static logic [7:0] lv[10] = '{8'hA0, 8'h60, 8'h61, 8'hA1, 8'h80, 8'h5F, 8'h9F, 8'h00,
                               8'hFF, 8'h7F};
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        `CHK(trimCode, FCAL[7:0])
        `CHK(busOe, 7'h00)
        rd(atr_pkg::OFF_TRIG, atr_pkg::TRIG_RESET, 32'hFFFF_FFFF);
        rd(atr_pkg::OFF_ROUTE, atr_pkg::ROUTE_RESET, 32'hFFFF_FFFF);
        rd(8'h1C, 32'h0000_0000, 32'hFFFF_FFFF);
        for (int sc = 0; sc < 2; sc++) begin
            for (int c = 0; c < 8; c++) begin
                tc = {12'h0, 8'hA0, 8'h60, c[2:0], sc[0]};
                wb(1'b1, atr_pkg::OFF_TRIG, tc, 4'hF);
                rd(atr_pkg::OFF_TRIG, tc, 32'h000F_FFFF);
                smp(c[2:0], sc[0], (c == 4) ? 8'hFF : 8'h00);
                foreach (lv[k]) smp(c[2:0], sc[0], lv[k]);
                repeat (3) smp(c[2:0], sc[0], 8'($random(seed)));
            end
        end
        wb(1'b1, 8'h1C, 32'hFFFF_FFFF, 4'hF);
        rd(atr_pkg::OFF_TRIG, tc, 32'h000F_FFFF);
        for (int k = 0; k < 12; k++) begin
            rt = 32'($random(seed)) & 32'h001F_FFFF;
            {intT, auxT, peerValue} <= 21'($random(seed));
            peerMaster <= ~rt[20:14];
            wb(1'b1, atr_pkg::OFF_ROUTE, rt, 4'hF);
            repeat (2) @(posedge clk);
            for (int i = 0; i < 7; i++) begin
                loc[i] = (rt[2*i +: 2] == atr_pkg::TSRC_AUX) ? auxT[i] : intT[i];
                te[i] = (rt[2*i +: 2] == atr_pkg::TSRC_BUS && !rt[14+i]) ? peerValue[i] : loc[i];
            end
            `CHK(busOe, rt[20:14])
            `CHK(busOut & rt[20:14], loc & rt[20:14])
            `CHK(timingOut, te)
            rd(atr_pkg::OFF_ROUTE, rt, 32'h001F_FFFF);
            rd(atr_pkg::OFF_STAT, {15'h0, te, 10'h0}, 32'h0001_FC00);
        end
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({timingOut, busOe}, 14'h0000)
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({timingOut, busOe}, {intT, 7'h00})
        for (int b = 1; b < 4; b++) begin
            rec[b] = $random(seed);
            wb(1'b1, atr_pkg::OFF_CALREC, rec[b], 4'hF);
            wb(1'b1, atr_pkg::OFF_CALCMD, 32'h0000_0010 | b, 4'hF);
        end
        wb(1'b1, atr_pkg::OFF_CALREC, 32'h0000_00C3, 4'hF);
        rd(atr_pkg::OFF_CALREC, 32'h0000_00C3, 32'hFFFF_FFFF);
        wb(1'b1, atr_pkg::OFF_CALCMD, 32'h0000_0010, 4'hF);
        for (int b = 3; b >= 0; b--) begin
            wb(1'b1, atr_pkg::OFF_CALCMD, 32'h0000_0020 | b, 4'hF);
            @(posedge clk);
            `CHK(trimCode, (b == 0) ? FCAL[7:0] : rec[b][7:0])
            rd(atr_pkg::OFF_CALCMD, b, 32'h0000_0003);
        end
        wb(1'b1, atr_pkg::OFF_CALCMD, 32'h0000_0021, 4'hE);
        @(posedge clk);
        `CHK(trimCode, FCAL[7:0])
        repeat (4) @(posedge clk);
        conclude();
    end
endmodule : analog_trigger_and_timing_routing_bench
